// ==== dv/hdsq_jack_mdl.sv ====
`timescale 1ns/1ns
module hdsq_jack_mdl
    import hdsq_pkg::*;
(
    input  wire logic      clk,
    input  wire hdsq_acc_t acc,
    output logic           sense_b,
    output logic           mic_r2,
    output logic           mic_sl
);
    // Comparators read low with no plug: no bias current can flow
    initial begin
        sense_b = 1'b1;
        mic_r2  = 1'b0;
        mic_sl  = 1'b0;
    end
    always @(posedge clk) begin
        sense_b <= (acc == HDSQ_ACC_NONE);
        mic_r2  <= (acc == HDSQ_ACC_4ALT);
        mic_sl  <= (acc == HDSQ_ACC_4STD);
    end
endmodule : hdsq_jack_mdl

// ==== dv/hdsq_test.sv ====
`timescale 1ns/1ns
module hdsq_test;
    import hdsq_pkg::*;
    localparam int unsigned CM = 10;
    localparam int unsigned DT = DET_MS * CM;
    logic       mclk = 1'b0;
    logic       rst_b = 1'b0;
    hdsq_acc_t  acc = HDSQ_ACC_NONE;
    logic       sense_b, on_r2, on_sl, int_b, micf_b, radio, slp;
    logic       cmd = 1'b0, ovr = 1'b0, kden = 1'b0, pass = 1'b0;
    logic       rd = 1'b0;
    logic [1:0] deb = DEB_SEL_RST;
    logic [6:0] hsw = 7'h2A;
    logic [3:0] keys = 4'h0;
    logic [6:0] sw;
    logic [1:0] atype;
    logic [3:0] kp, kr;
    int         fail_count = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         n;
    int unsigned dms [4] = '{DEB_MS0, DEB_MS1, DEB_90_MS, DEB_MS3};
    logic [6:0] swx [3] = '{SW_3POLE, SW_4STD, SW_4ALT};
    always #2 mclk = ~mclk;
    hdsq_jack_mdl hdsq_jack_mdl_i (.clk(mclk), .acc(acc),
        .sense_b(sense_b), .mic_r2(on_r2), .mic_sl(on_sl));
    hdsq_top #(.CYC_MS(CM)) hdsq_top_i (.MCLK(mclk), .RST_B(rst_b),
        .JACK_SENSE_B(sense_b), .DETECT_CMD(cmd), .MIC_ON_JACK_SECOND_RING(on_r2),
        .MIC_ON_SLEEVE(on_sl), .DEB_SEL(deb), .OVERRIDE_EN(ovr),
        .HOST_SW(hsw), .KEY_DET_EN(kden), .KEY_RAW(keys),
        .PASS_EN(pass), .STATUS_READ(rd), .SWITCH_STATE(sw),
        .INT_B(int_b), .MIC_FOUND_B(micf_b), .RADIO_PASS(radio),
        .SLEEPING(slp), .ACC_TYPE(atype), .KEY_PRESS(kp),
        .KEY_RELEASE(kr));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // Hang guard, well above the longest planned sequence
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(int c);
        repeat (c) @(negedge mclk);
    endtask : tick
    task automatic plug(hdsq_acc_t a);
        @(posedge mclk);
        acc <= a;
    endtask : plug
    // Counts cycles until the interrupt drops, bounded
    task automatic wait_int(output int c);
        c = 0;
        while (int_b !== 1'b0 && c < 2500) begin
            @(negedge mclk);
            c++;
        end
    endtask : wait_int
    task automatic rd_int();
        tick(50);
        chk("int_hold", 1'b0, int_b);
        @(posedge mclk);
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        tick(2);
        chk("int_clear", 1'b1, int_b);
    endtask : rd_int
    task automatic rem();
        plug(HDSQ_ACC_NONE);
        tick(5);
        chk("rem_sw", SW_NONE, sw);
        chk("rem_int", 1'b0, int_b);
        chk("rem_mic", 1'b1, micf_b);
        rd_int();
        tick(REM_MS * CM + 20);
        chk("rem_sleep", 1'b1, slp);
    endtask : rem
    // Presses or releases one key and looks for its one-cycle pulse
    task automatic key(int k, logic v, logic exp);
        logic f;
        f = 1'b0;
        @(posedge mclk);
        keys[k] <= v;
        repeat (20) begin
            @(negedge mclk);
            f = f | (v ? kp[k] : kr[k]);
        end
        chk(v ? "key_press" : "key_release", exp, f);
    endtask : key
    initial begin
        tick(16);
        @(posedge mclk);
        rst_b <= 1'b1;
        tick(3);
        chk("rst_sw", SW_NONE, sw);
        chk("rst_sleep", 1'b1, slp);
        chk("rst_type", HDSQ_ACC_NONE, atype);
        for (int d = 0; d < 4; d++) begin
            @(posedge mclk);
            deb <= 2'(d);
            tick(3);
            chk("sleep_cfg", 1'b1, slp);
            plug(HDSQ_ACC_3POLE);
            wait_int(n);
            chk("deb_time", 1'b1, 1'(n >= dms[d] * CM + DT
                && n <= dms[d] * CM + DT + 12));
            chk("route_first", SW_3POLE, sw);
            rd_int();
            rem();
        end
        @(posedge mclk);
        deb <= DEB_SEL_RST;
        for (int t = 0; t < 3; t++) begin
            @(posedge mclk);
            pass <= (t == 1);
            plug(hdsq_acc_t'(t));
            wait_int(n);
            chk("sw_type", swx[t], sw);
            chk("acc_type", 8'(t), atype);
            chk("mic_found", (t == 0), micf_b);
            chk("radio", (t == 1), radio);
            rd_int();
            rem();
        end
        plug(HDSQ_ACC_4STD);
        wait_int(n);
        rd_int();
        @(posedge mclk);
        cmd <= 1'b1;
        @(posedge mclk);
        cmd <= 1'b0;
        wait_int(n);
        chk("cmd_det", 1'b1, 1'(n <= DT + 12));
        rd_int();
        key(0, 1'b1, 1'b0);
        key(0, 1'b0, 1'b0);
        @(posedge mclk);
        kden <= 1'b1;
        for (int k = 0; k < KEY_N; k++) begin
            key(k, 1'b1, 1'b1);
            key(k, 1'b0, 1'b1);
        end
        key(2, 1'b1, 1'b1);
        rem();
        @(posedge mclk);
        keys <= 4'h0;
        kden <= 1'b0;
        plug(HDSQ_ACC_3POLE);
        tick(300);
        plug(HDSQ_ACC_NONE);
        tick(4);
        plug(HDSQ_ACC_3POLE);
        wait_int(n);
        chk("deb_restart", 1'b1, 1'(n >= DEB_90_MS * CM + DT));
        rd_int();
        rem();
        plug(HDSQ_ACC_3POLE);
        tick(300);
        plug(HDSQ_ACC_NONE);
        tick(1200);
        chk("deb_abort_int", 1'b1, int_b);
        chk("deb_abort_type", HDSQ_ACC_NONE, atype);
        chk("deb_abort_sleep", 1'b1, slp);
        @(posedge mclk);
        ovr <= 1'b1;
        tick(4);
        chk("ovr_sw", hsw, sw);
        chk("ovr_wake", 1'b0, slp);
        plug(HDSQ_ACC_4STD);
        wait_int(n);
        rd_int();
        plug(HDSQ_ACC_NONE);
        tick(5);
        chk("ovr_rem_sw", hsw, sw);
        tick(REM_MS * CM + 20);
        chk("ovr_awake", 1'b0, slp);
        @(posedge mclk);
        ovr <= 1'b0;
        tick(4);
        chk("ovr_off_sw", SW_NONE, sw);
        chk("ovr_off_sleep", 1'b1, slp);
        end_of_test();
    end
endmodule : hdsq_test

// ==== rtl/hdsq_pkg.sv ====
// Behaviour
// - Removal aborts any step, highest priority
// - Removal during debounce returns to idle wait
// - Removal after debounce goes to removal state
// - Override keeps host switches on removal
// - Detection starts from sense pin or command
// - Mic bias feed open before insertion
// - Mic found routes mic input and ground
// - Key detect off until host enables it
// - Four keys, press and release reported
// - Radio passthrough only when enable bit set
// - Selectable insertion debounce, reset 90 ms
// - Sleep when empty and override off
// - Insertion in sleep wakes and detects
// - Settings accepted while asleep
// - Override set powers up, leaves sleep
// - Override cleared when empty returns sleep
// - Debounce restarts whenever sense goes high
// - Switches set before interrupt and mic flag
// - Interrupt held until host reads status
// - Removal switches now, 50 ms then sleep
package hdsq_pkg;
    localparam int unsigned CLK_MHZ     = 250;
    localparam int unsigned DEB_90_MS   = 90;
    localparam int unsigned REM_MS      = 50;
    localparam int unsigned DET_MS      = 10;
    localparam int unsigned CYC_PER_MS  = CLK_MHZ * 1000;
    localparam int unsigned REM_CYC     = REM_MS * CYC_PER_MS;
    localparam int unsigned DET_CYC     = DET_MS * CYC_PER_MS;
    localparam int unsigned CNT_W       = 32;
    localparam logic [1:0]  DEB_SEL_RST = 2'h2;
    localparam int unsigned KEY_N       = 4;
    // Debounce choices in ms, index 2 is the reset value
    localparam int unsigned DEB_MS0 = 30;
    localparam int unsigned DEB_MS1 = 60;
    localparam int unsigned DEB_MS3 = 180;
    // Switch word: [0] mic to jack_second_ring, [1] mic to sleeve,
    // [2] gnd to jack_second_ring, [3] gnd to sleeve, [4] bias feed,
    // [5] jack_second_ring pulldown, [6] sleeve pulldown
    localparam int unsigned SW_W = 7;
    localparam logic [6:0] SW_NONE   = 7'h60;
    localparam logic [6:0] SW_3POLE  = 7'h0C;
    localparam logic [6:0] SW_4STD   = 7'h16;
    localparam logic [6:0] SW_4ALT   = 7'h19;
    typedef enum logic [1:0] {
        HDSQ_ACC_3POLE,
        HDSQ_ACC_4STD,
        HDSQ_ACC_4ALT,
        HDSQ_ACC_NONE
    } hdsq_acc_t;
endpackage : hdsq_pkg

// ==== rtl/hdsq_tmr.sv ====
`timescale 1ns/1ns
module hdsq_tmr
    import hdsq_pkg::*;
(
    input  wire logic MCLK,
    input  wire logic RST_B,
    hdsq_tmr_if.tmr   t
);
    logic [CNT_W-1:0] cnt_q;
    // Done holds once reached so a late sampler never misses it
    assign t.done = (cnt_q >= t.limit);
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_q <= '0;
        end else if (t.clr) begin
            cnt_q <= '0;
        end else if (!t.done) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule : hdsq_tmr

// ==== rtl/hdsq_tmr_if.sv ====
`timescale 1ns/1ns
interface hdsq_tmr_if;
    import hdsq_pkg::*;
    logic             clr;
    logic [CNT_W-1:0] limit;
    logic             done;
    modport ctl (output clr, output limit, input done);
    modport tmr (input clr, input limit, output done);
endinterface : hdsq_tmr_if

// ==== rtl/hdsq_top.sv ====
`timescale 1ns/1ns
module hdsq_top
    import hdsq_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS
)
(
    input  wire logic       MCLK,
    input  wire logic       RST_B,
    input  wire logic       JACK_SENSE_B,
    input  wire logic       DETECT_CMD,
    input  wire logic       MIC_ON_JACK_SECOND_RING,
    input  wire logic       MIC_ON_SLEEVE,
    input  wire logic [1:0] DEB_SEL,
    input  wire logic       OVERRIDE_EN,
    input  wire logic [6:0] HOST_SW,
    input  wire logic       KEY_DET_EN,
    input  wire logic [3:0] KEY_RAW,
    input  wire logic       PASS_EN,
    input  wire logic       STATUS_READ,
    output logic [6:0]      SWITCH_STATE,
    output logic            INT_B,
    output logic            MIC_FOUND_B,
    output logic            RADIO_PASS,
    output logic            SLEEPING,
    output logic [1:0]      ACC_TYPE,
    output logic [3:0]      KEY_PRESS,
    output logic [3:0]      KEY_RELEASE
);
    typedef enum logic [2:0] {
        HDSQ_SLEEP, HDSQ_DEBOUNCE, HDSQ_DETECT, HDSQ_ROUTE,
        HDSQ_ACTIVE, HDSQ_REMOVE
    } hdsq_st_t;

    hdsq_st_t st_q, st_d;
    logic [1:0]  sense_sq, cmd_sq, r2_sq, sl_sq;
    logic [3:0]  key_s1_q, key_s2_q, key_q;
    logic [6:0]  auto_sw_q, auto_sw_d;
    logic        int_q, mic_q, rel_q;
    hdsq_acc_t   acc_q;
    logic        ovr_q;

    // Sense, command, mic and key pins pass two flip-flops before use
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            sense_sq <= 2'h3;
            cmd_sq   <= 2'h0;
            r2_sq    <= 2'h0;
            sl_sq    <= 2'h0;
            key_s1_q <= 4'h0;
            key_s2_q <= 4'h0;
        end else begin
            sense_sq <= {sense_sq[0], JACK_SENSE_B};
            cmd_sq   <= {cmd_sq[0], DETECT_CMD};
            r2_sq    <= {r2_sq[0], MIC_ON_JACK_SECOND_RING};
            sl_sq    <= {sl_sq[0], MIC_ON_SLEEVE};
            key_s1_q <= KEY_RAW;
            key_s2_q <= key_s1_q;
        end
    end

    wire jack_in   = ~sense_sq[1];
    wire det_cmd   = cmd_sq[1];
    wire mic_r2    = r2_sq[1];
    wire mic_sl    = sl_sq[1];
    wire removed   = ~jack_in;
    wire cmd_start = det_cmd & jack_in;

    // Debounce terminal count from selected duration
    logic [CNT_W-1:0] deb_ms;
    always_comb begin
        unique case (DEB_SEL)
            2'h0: deb_ms = CNT_W'(DEB_MS0);
            2'h1: deb_ms = CNT_W'(DEB_MS1);
            2'h2: deb_ms = CNT_W'(DEB_90_MS);
            2'h3: deb_ms = CNT_W'(DEB_MS3);
        endcase
    end
    wire [CNT_W-1:0] deb_lim = CNT_W'(deb_ms * CYC_MS);

    hdsq_tmr_if tmr_i ();
    wire jump = (st_q != st_d);
    assign tmr_i.clr   = jump | (st_q == HDSQ_DEBOUNCE & removed);
    assign tmr_i.limit = (st_q == HDSQ_DEBOUNCE) ? deb_lim
                       : (st_q == HDSQ_REMOVE)   ? CNT_W'(REM_MS * CYC_MS)
                       : CNT_W'(DET_MS * CYC_MS);
    hdsq_tmr u_tmr (.MCLK(MCLK), .RST_B(RST_B), .t(tmr_i.tmr));

    // Sequencer; removal is checked first in every live state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            HDSQ_SLEEP: begin
                if (jack_in) st_d = HDSQ_DEBOUNCE;
            end
            HDSQ_DEBOUNCE: begin
                if (removed) st_d = HDSQ_SLEEP;
                else if (tmr_i.done | cmd_start) st_d = HDSQ_DETECT;
            end
            HDSQ_DETECT: begin
                if (removed) st_d = HDSQ_REMOVE;
                else if (tmr_i.done) st_d = HDSQ_ROUTE;
            end
            HDSQ_ROUTE: begin
                if (removed) st_d = HDSQ_REMOVE;
                else st_d = HDSQ_ACTIVE;
            end
            HDSQ_ACTIVE: begin
                if (removed) st_d = HDSQ_REMOVE;
                else if (cmd_start) st_d = HDSQ_DETECT;
            end
            HDSQ_REMOVE: begin
                if (tmr_i.done) st_d = HDSQ_SLEEP;
            end
        endcase
    end

    // Detection result picks the switch pattern
    wire hdsq_acc_t acc_d = mic_sl ? HDSQ_ACC_4STD
                          : mic_r2 ? HDSQ_ACC_4ALT : HDSQ_ACC_3POLE;
    wire [6:0] found_sw = (acc_d == HDSQ_ACC_4STD) ? SW_4STD
                        : (acc_d == HDSQ_ACC_4ALT) ? SW_4ALT : SW_3POLE;
    always_comb begin
        auto_sw_d = auto_sw_q;
        if (st_d == HDSQ_SLEEP || st_d == HDSQ_REMOVE)
            auto_sw_d = SW_NONE;
        else if (st_q == HDSQ_DETECT && st_d == HDSQ_ROUTE)
            auto_sw_d = found_sw;
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            st_q      <= HDSQ_SLEEP;
            auto_sw_q <= SW_NONE;
            acc_q     <= HDSQ_ACC_NONE;
        end else begin
            st_q      <= st_d;
            auto_sw_q <= auto_sw_d;
            if (st_q == HDSQ_DETECT && st_d == HDSQ_ROUTE)
                acc_q <= acc_d;
            else if (st_d == HDSQ_REMOVE || st_d == HDSQ_SLEEP)
                acc_q <= HDSQ_ACC_NONE;
        end
    end

    // Override enable is sampled only outside detection and debounce; ovr_q holds its value there
    wire ovr_blocked = (st_q == HDSQ_DEBOUNCE) | (st_q == HDSQ_DETECT);
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) ovr_q <= 1'b0;
        else if (!ovr_blocked) ovr_q <= OVERRIDE_EN;
    end

    // Event flags: set wins over clear; the read clears only the interrupt
    wire ev_found  = (st_q == HDSQ_ROUTE) & ~removed;
    wire ev_remove = (st_d == HDSQ_REMOVE) & (st_q != HDSQ_REMOVE);
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            int_q <= 1'b0;
            mic_q <= 1'b0;
        end else begin
            if (ev_found | ev_remove) int_q <= 1'b1;
            else if (STATUS_READ) int_q <= 1'b0;
            if (ev_found) mic_q <= (acc_q != HDSQ_ACC_3POLE);
            else if (ev_remove | (st_q == HDSQ_SLEEP)) mic_q <= 1'b0;
        end
    end

    // Key events only in a settled four-contact state
    wire key_ok = KEY_DET_EN & (st_q == HDSQ_ACTIVE) &
                  (acc_q != HDSQ_ACC_3POLE) & (acc_q != HDSQ_ACC_NONE);
    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
            key_q       <= 4'h0;
            KEY_PRESS   <= 4'h0;
            KEY_RELEASE <= 4'h0;
        end else begin
            key_q       <= key_ok ? key_s2_q : 4'h0;
            KEY_PRESS   <= key_ok ? (key_s2_q & ~key_q) : 4'h0;
            KEY_RELEASE <= key_ok ? (~key_s2_q & key_q) : 4'h0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) rel_q <= 1'b0;
        else rel_q <= 1'b1;
    end

    // Override wins over auto routing, removal included
    assign SWITCH_STATE = ovr_q ? HOST_SW : auto_sw_q;
    assign INT_B       = ~int_q;
    assign MIC_FOUND_B = ~mic_q;
    assign RADIO_PASS  = PASS_EN & (acc_q != HDSQ_ACC_NONE);
    // Config inputs are live in sleep; the flag needs the sleep state, override off and one cycle out of reset
    assign SLEEPING    = (st_q == HDSQ_SLEEP) & ~ovr_q & rel_q;
    assign ACC_TYPE    = acc_q;

    // Sequencer, flag, key and sleep checks; reset holds them all off
    property p_rem_jump;
        @(posedge MCLK) disable iff (!RST_B)
        (st_q == HDSQ_ACTIVE && removed) |=> st_q == HDSQ_REMOVE;
    endproperty
    a_rem_jump: assert property (p_rem_jump)
        else $error("removal not taken");

    property p_det_abort;
        @(posedge MCLK) disable iff (!RST_B)
        (st_q == HDSQ_DETECT && removed) |=> st_q == HDSQ_REMOVE;
    endproperty
    a_det_abort: assert property (p_det_abort)
        else $error("detection not aborted");

    property p_route_abort;
        @(posedge MCLK) disable iff (!RST_B)
        (st_q == HDSQ_ROUTE && removed) |=> st_q == HDSQ_REMOVE;
    endproperty
    a_route_abort: assert property (p_route_abort)
        else $error("routing not aborted");

    property p_deb_abort;
        @(posedge MCLK) disable iff (!RST_B)
        (st_q == HDSQ_DEBOUNCE && removed) |=> st_q == HDSQ_SLEEP;
    endproperty
    a_deb_abort: assert property (p_deb_abort)
        else $error("debounce abort wrong");

    property p_wake;
        @(posedge MCLK) disable iff (!RST_B)
        (st_q == HDSQ_SLEEP && jack_in) |=> st_q == HDSQ_DEBOUNCE;
    endproperty
    a_wake: assert property (p_wake)
        else $error("insertion did not wake");

    property p_cmd_start;
        @(posedge MCLK) disable iff (!RST_B)
        (st_q == HDSQ_ACTIVE && cmd_start) |=> st_q == HDSQ_DETECT;
    endproperty
    a_cmd_start: assert property (p_cmd_start)
        else $error("detect command ignored");

    property p_rem_wait;
        @(posedge MCLK) disable iff (!RST_B)
        (st_q == HDSQ_REMOVE && !tmr_i.done) |=> st_q == HDSQ_REMOVE;
    endproperty
    a_rem_wait: assert property (p_rem_wait)
        else $error("removal wait cut short");

    property p_tmr_clr;
        @(posedge MCLK) disable iff (!RST_B)
        jump |=> !tmr_i.done;
    endproperty
    a_tmr_clr: assert property (p_tmr_clr)
        else $error("timer not cleared on jump");

    property p_int_hold;
        @(posedge MCLK) disable iff (!RST_B)
        (!INT_B && !STATUS_READ) |=> !INT_B;
    endproperty
    a_int_hold: assert property (p_int_hold)
        else $error("int dropped");

    property p_int_clear;
        @(posedge MCLK) disable iff (!RST_B)
        (STATUS_READ && !ev_found && !ev_remove) |=> INT_B;
    endproperty
    a_int_clear: assert property (p_int_clear)
        else $error("int not released by read");

    property p_route_first;
        @(posedge MCLK) disable iff (!RST_B)
        ($fell(INT_B) && st_q == HDSQ_ACTIVE) |-> auto_sw_q != SW_NONE;
    endproperty
    a_route_first: assert property (p_route_first)
        else $error("int before routing");

    property p_mic_flag;
        @(posedge MCLK) disable iff (!RST_B)
        $fell(MIC_FOUND_B) |-> auto_sw_q[4];
    endproperty
    a_mic_flag: assert property (p_mic_flag)
        else $error("mic flag before bias routed");

    property p_gnd_route;
        @(posedge MCLK) disable iff (!RST_B)
        (st_q == HDSQ_ROUTE) |-> auto_sw_q[3:2] != 2'h0;
    endproperty
    a_gnd_route: assert property (p_gnd_route)
        else $error("ground not routed");

    property p_bias_open;
        @(posedge MCLK) disable iff (!RST_B)
        (st_q == HDSQ_SLEEP) |-> auto_sw_q == SW_NONE;
    endproperty
    a_bias_open: assert property (p_bias_open)
        else $error("bias not isolated");

    property p_ovr_sw;
        @(posedge MCLK) disable iff (!RST_B)
        (ovr_q && OVERRIDE_EN && ev_remove) |=> SWITCH_STATE == HOST_SW;
    endproperty
    a_ovr_sw: assert property (p_ovr_sw)
        else $error("override ignored");

    property p_sleep_ovr;
        @(posedge MCLK) disable iff (!RST_B)
        (OVERRIDE_EN && !ovr_blocked) |=> !SLEEPING;
    endproperty
    a_sleep_ovr: assert property (p_sleep_ovr)
        else $error("override did not wake");

    property p_key_off;
        @(posedge MCLK) disable iff (!RST_B)
        !$past(KEY_DET_EN) |-> KEY_PRESS == 4'h0;
    endproperty
    a_key_off: assert property (p_key_off)
        else $error("key while disabled");

    property p_key_state;
        @(posedge MCLK) disable iff (!RST_B)
        (KEY_PRESS != 4'h0) |->
            $past(st_q) == HDSQ_ACTIVE && $past(acc_q) != HDSQ_ACC_3POLE;
    endproperty
    a_key_state: assert property (p_key_state)
        else $error("key outside four-contact state");

    property p_rem_sw;
        @(posedge MCLK) disable iff (!RST_B)
        ev_remove |=> auto_sw_q == SW_NONE && !INT_B;
    endproperty
    a_rem_sw: assert property (p_rem_sw)
        else $error("removal response late");

    property p_rem_mic;
        @(posedge MCLK) disable iff (!RST_B)
        ev_remove |=> MIC_FOUND_B;
    endproperty
    a_rem_mic: assert property (p_rem_mic)
        else $error("mic flag kept after removal");

    property p_sleep;
        @(posedge MCLK) disable iff (!RST_B)
        ##1 (st_q == HDSQ_SLEEP && !ovr_q) |-> SLEEPING;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("not sleeping");

    c_found: cover property (@(posedge MCLK) ev_found);
    c_remove: cover property (@(posedge MCLK) ev_remove);
    c_key: cover property (@(posedge MCLK) |KEY_PRESS);
    c_wake: cover property (@(posedge MCLK) st_q == HDSQ_SLEEP && jack_in);
    c_ovr_rem: cover property (@(posedge MCLK) ovr_q && ev_remove);
endmodule : hdsq_top
